// File: dv/cbad_checker.sv
/* Concurrent checks on the board glue decoder ports.
   Bound into cbad_decoder; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module cbad_checker
   import cbad_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic [15:0] cpu_addr,
   input wire logic        cpu_rw,
   input wire logic        valid_memory_access,
   input wire logic        bus_available,
   input wire logic        watchdog_timeout,
   input wire logic        cpu_reset_n,
   input wire logic        bus_reset_n,
   input wire logic        phase_two,
   input wire logic        io_space_enable,
   input wire logic        rom_enable_decode,
   input wire cbad_sel_t   sel,
   input wire logic        ram_write_n,
   input wire cbad_buf_t   buf_en
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_wd_rise;
      $rose(watchdog_timeout);
   endsequence
   sequence s_phase_edge;
      $changed(phase_two);
   endsequence
   a_io_space_decode: assert property (io_space_enable ==
      (cpu_addr[15:13] == 3'h4 && valid_memory_access)) else $error("io enable wrong");
   a_timer_chip_sel: assert property (sel.timer_select ==
      (io_space_enable && cpu_addr[12:9] == 4'hF)) else $error("timer select wrong");
   a_drive_enable: assert property (buf_en.buffer_drive_enable ==
      (!cpu_rw && !bus_available && phase_two)) else $error("drive enable wrong");
   a_receive_enable: assert property (buf_en.buffer_receive_enable ==
      (cpu_rw && cpu_addr[15] && !cpu_addr[13] && phase_two)) else $error("receive wrong");
   a_ram_write_strobe: assert property (ram_write_n ==
      !(!cpu_rw && valid_memory_access && phase_two)) else $error("write strobe wrong");
   a_vector_alias: assert property (cpu_addr >= 16'hFFF8 |-> sel.rom_select_fourth)
      else $error("vector alias missing");
   a_ext_rom_gap: assert property (cpu_addr[15:13] == 3'h6 |-> sel[6:3] == 4'h0)
      else $error("external rom range selected");
   a_rom_one_hot: assert property (rom_enable_decode |-> $onehot(sel[6:3]))
      else $error("rom selects not one hot");
   a_bus_reset_same: assert property (bus_reset_n == cpu_reset_n)
      else $error("bus reset differs");
   a_watchdog_reset: assert property (s_wd_rise |-> ##[1:4] !cpu_reset_n)
      else $error("watchdog reset late");
   a_e_clk_half: assert property (s_phase_edge |=> $stable(phase_two)[*8])
      else $error("e clock half period short");
endmodule
bind cbad_decoder cbad_checker cbad_checker_inst (.sys_clk, .arst_n, .cpu_addr, .cpu_rw,
   .valid_memory_access, .bus_available, .watchdog_timeout, .cpu_reset_n, .bus_reset_n,
   .phase_two, .io_space_enable, .rom_enable_decode, .sel, .ram_write_n, .buf_en);
`default_nettype wire

// File: dv/cbad_decoder_tb.sv
/* Self-checking bench of the board glue decoder.
   Assumes the checker bind and the timer model. */
`timescale 1ns/1ps
`default_nettype none
module cbad_decoder_tb;
   import cbad_pkg::*;
   localparam int unsigned POR = 50;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        cpu_rw = 1'b1;
   logic        valid_memory_access = 1'b1;
   logic        bus_available = 1'b0;
   logic        rom_cfg_4k = 1'b0;
   logic        starve = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic        watchdog_timeout, timer3_irq_n, timer2_tone, cpu_reset_n, bus_reset_n;
   logic        e_clk, phase_two, io_space_enable, ram_write_n, cpu_irq_n, tone_test_point;
   logic [2:0]  timer_reg_select;
   logic [15:0] buffered_addr;
   logic        dma_grant, buffered_io_space_enable, ram_enable_decode;
   logic [1:0]  ram_nibble_select_lo;
   cbad_sel_t   sel;
   cbad_buf_t   buf_en;
   int          failures = 0;
   int          n_tests = 0;
   logic [15:0] ad [11] = '{16'hA000, 16'hA800, 16'hB000, 16'hB800, 16'hFFF8, 16'hC000,
                            16'hDFFF, 16'h9E03, 16'h0000, 16'h0400, 16'h0800};
   logic [6:0]  ex2 [11] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h08, 7'h00, 7'h00, 7'h01, 7'h04,
                             7'h02, 7'h00};
   logic [6:0]  ex4 [11] = '{7'h10, 7'h10, 7'h08, 7'h08, 7'h08, 7'h00, 7'h00, 7'h01, 7'h04,
                             7'h02, 7'h00};
   cbad_decoder #(.POR_COUNT(POR)) cbad_decoder_inst (.sys_clk, .arst_n, .cpu_addr, .cpu_rw,
      .valid_memory_access, .bus_available, .watchdog_timeout, .timer3_irq_n, .timer2_tone,
      .rom_cfg_4k, .cpu_reset_n, .bus_reset_n, .e_clk, .phase_two, .buffered_addr,
      .buffered_rw(), .buffered_valid_access(), .dma_grant, .io_space_enable,
      .buffered_io_space_enable, .rom_enable_decode(), .ram_enable_decode, .sel,
      .ram_nibble_select_lo, .ram_nibble_select_hi(), .timer_reg_select, .ram_write_n,
      .buf_en, .cpu_irq_n, .tone_test_point);
   cbad_timer_model cbad_timer_model_inst (.sys_clk, .arst_n, .starve, .watchdog_timeout,
      .timer3_irq_n, .timer2_tone);
   task automatic step;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic phase_start;
      while (phase_two) step;
      while (!phase_two) step;
   endtask
   task automatic t_por;
      repeat (POR - 10) step;
      chk(cpu_reset_n, 1'b0);
      chk(bus_reset_n, 1'b0);
      repeat (20) step;
      chk(cpu_reset_n, 1'b1);
      chk(bus_reset_n, 1'b1);
      $display("por done");
   endtask
   task automatic t_eclk;
      int n;
      n = 0;
      while (e_clk) step;
      while (!e_clk) step;
      while (e_clk)
      begin
         chk(phase_two, e_clk);
         n++;
         step;
      end
      chk(n[15:0], 16'h0014);
      $display("eclk done");
   endtask
   task automatic t_map(input logic [6:0] ex [11]);
      phase_start;
      for (int i = 0; i < 11; i++)
      begin
         cpu_addr = ad[i];
         step;
         chk(sel, ex[i]);
         chk(buffered_addr, ad[i]);
      end
      cpu_addr = 16'h9E03;
      step;
      chk(timer_reg_select, 3'h3);
      chk(io_space_enable, 1'b1);
      chk(buffered_io_space_enable, 1'b1);
      cpu_addr = 16'h0000;
      step;
      chk(ram_enable_decode, 1'b1);
      chk(ram_nibble_select_lo, 2'h3);
      $display("map done");
   endtask
   task automatic t_bus;
      cpu_addr = 16'h8000;
      phase_start;
      cpu_rw = 1'b0;
      step;
      chk(buf_en, 2'h2);
      chk(ram_write_n, 1'b0);
      bus_available = 1'b1;
      step;
      chk(buf_en, 2'h0);
      chk(dma_grant, 1'b1);
      bus_available = 1'b0;
      cpu_rw = 1'b1;
      step;
      chk(buf_en, 2'h1);
      cpu_rw = 1'b0;
      while (phase_two) step;
      chk(buf_en, 2'h0);
      chk(ram_write_n, 1'b1);
      cpu_rw = 1'b1;
      $display("bus done");
   endtask
   task automatic t_watchdog;
      starve = 1'b1;
      step;
      starve = 1'b0;
      repeat (6) step;
      chk(cpu_reset_n, 1'b0);
      repeat (POR + 10) step;
      chk(cpu_reset_n, 1'b1);
      $display("watchdog done");
   endtask
   task automatic t_timers;
      int lows;
      lows = 0;
      while (timer3_irq_n) step;
      repeat (128)
      begin
         step;
         chk(tone_test_point, timer2_tone);
         if (cpu_irq_n === 1'b0) lows++;
      end
      chk(lows[15:0], 16'h0006);
      $display("timers done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial
   begin
      #100us;
      failures++;
      wrap_up;
   end
   initial
   begin
      repeat (2) step;
      arst_n = 1'b1;
      t_por;
      t_eclk;
      t_map(ex2);
      t_bus;
      t_watchdog;
      rom_cfg_4k = 1'b1;
      t_timers;
      arst_n = 1'b0;
      repeat (4) step;
      arst_n = 1'b1;
      t_map(ex4);
      wrap_up;
   end
endmodule
`default_nettype wire

// File: dv/cbad_timer_model.sv
/* Behavioural timer peripheral beside the glue decoder.
   Assumes sys_clk and arst_n of the bench; starve withholds service. */
`timescale 1ns/1ps
`default_nettype none
module cbad_timer_model
(
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic starve,
   output logic      watchdog_timeout,
   output logic      timer3_irq_n,
   output logic      timer2_tone
);
   logic [5:0] cnt_r;
   logic [2:0] wd_r;
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_r       <= 6'h00;
         wd_r        <= 3'h0;
         timer2_tone <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_r + 6'h01;
         if (cnt_r[2:0] == 3'h7)
            timer2_tone <= ~timer2_tone;
         wd_r <= starve ? 3'h4 : wd_r - {2'h0, wd_r != 3'h0};
      end
   end
   assign watchdog_timeout = wd_r != 3'h0;
   assign timer3_irq_n     = cnt_r > 6'h02;
endmodule
`default_nettype wire

// File: logic/cbad_decoder.sv
/*
 Processor board glue: power-on reset stretcher with watchdog restart,
 E clock divider, address decode for ROM, RAM, I/O and timer, vector
 alias, RAM write strobe and data buffer direction.
 Assumes address and control come from logic on sys_clk; the watchdog,
 timer 3 interrupt and the PROM size strap are pins and are synchronised; the timer 2 tone is not.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R01) Hold processor reset asserted for 20 ms after power is applied.
// (R02) Drive the same stretched reset onto the system bus for peripherals.
// (R03) Timer select from buffered A12..A9 and buffered I/O enable, 9E00-9FFF.
// (R04) Timer registers chosen by three select bits plus read/write.
// (R05) Timer 1 output acts as watchdog and resets the processor.
// (R06) Timer 3 delivers periodic real-time interrupts to the processor.
// (R07) Timer 2 drives a 120 Hz square signal onto a test point.
// (R08) Drive enable from read/write, bus-available, phase two; processor writing.
// (R09) Receive enable from phase two, A15, A13 and read/write.
// (R10) All buffer enables qualified by phase two.
// (R11) I/O enable from A15..A13 and valid access; a buffered copy goes out.
// (R12) Top ROM block also answers FFF8-FFFF for processor vectors.
// (R13) 2K parts: fourth ROM select covers B800-BFFF or the vector range.
// (R14) 2K parts: second select A800-AFFF, third select B000-B7FF.
// (R15) 4K parts: third A000-AFFF, fourth B000-BFFF; 8K ROM total.
// (R16) C000-DFFF never selects on-board ROM; left for external ROM.
// (R17) ROM enable gates a 1-of-4 decoder on A11 and A12.
// (R18) RAM enable from A14, A15 and phase two; it gates the bank decoder.
// (R19) With A13 low, A10 picks lower or upper 1K bank up to 07FF.
// (R20) Each bank is two 4-bit devices selected together for one byte.
// (R21) RAM write strobe only on a valid write during phase two.
// (R22) E clock is crystal divided by four, 1 MHz.
// (R23) At most one select per address except the vector alias; all combinational.
module cbad_decoder
   import cbad_pkg::*;
#(
   parameter int unsigned POR_COUNT = POR_CYCLES
)
(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_rw,
   input  wire logic        valid_memory_access,
   input  wire logic        bus_available,
   input  wire logic        watchdog_timeout,
   input  wire logic        timer3_irq_n,
   input  wire logic        timer2_tone,
   input  wire logic        rom_cfg_4k,
   output logic             cpu_reset_n,
   output logic             bus_reset_n,
   output logic             e_clk,
   output logic             phase_two,
   output logic [15:0]      buffered_addr,
   output logic             buffered_rw,
   output logic             buffered_valid_access,
   output logic             dma_grant,
   output logic             io_space_enable,
   output logic             buffered_io_space_enable,
   output logic             rom_enable_decode,
   output logic             ram_enable_decode,
   output cbad_sel_t        sel,
   output logic [1:0]       ram_nibble_select_lo,
   output logic [1:0]       ram_nibble_select_hi,
   output logic [2:0]       timer_reg_select,
   output logic             ram_write_n,
   output cbad_buf_t        buf_en,
   output logic             cpu_irq_n,
   output logic             tone_test_point
);

   localparam int unsigned PW = $clog2(POR_COUNT + 1);
   localparam int unsigned EW = $clog2(E_HALF_CYCLES + 1);
   localparam logic [PW-1:0] POR_LOAD = PW'(POR_COUNT);
   localparam logic [EW-1:0] E_LAST   = EW'(E_HALF_CYCLES - 1);

   // Pin synchronisers: first stage feeds only the second
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic       wdog_s;
   logic       irq_s;
   logic       strap_s;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // Idle levels: strap low, interrupt high, watchdog low
         sync1_r <= 3'h2;
         sync2_r <= 3'h2;
      end
      else
      begin
         sync1_r <= {rom_cfg_4k, timer3_irq_n, watchdog_timeout};
         sync2_r <= sync1_r;
      end
   end

   assign wdog_s  = sync2_r[0];
   assign irq_s   = sync2_r[1];
   assign strap_s = sync2_r[2];

   // Reset stretcher; a watchdog timeout restarts the full pulse
   logic [PW-1:0] por_cnt_r;
   logic [PW-1:0] por_cnt_nxt;
   logic          reset_hold_r;

   assign por_cnt_nxt = wdog_s ? POR_LOAD                                   // R05
                      : (por_cnt_r != '0) ? por_cnt_r - PW'(1) : por_cnt_r; // R01

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         por_cnt_r    <= POR_LOAD;
         reset_hold_r <= 1'b1;
      end
      else
      begin
         por_cnt_r    <= por_cnt_nxt;
         reset_hold_r <= (por_cnt_nxt != '0);
      end
   end

   assign cpu_reset_n = ~reset_hold_r; // R01
   assign bus_reset_n = ~reset_hold_r; // R02

   // PROM size strap sampled while reset is held, fixed after release
   logic cfg_4k_r;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         cfg_4k_r <= 1'b0;
      else if (reset_hold_r)
         cfg_4k_r <= strap_s;
   end

   // E clock: crystal rate divided by four, from the system clock
   logic [EW-1:0] e_cnt_r;
   logic          e_clk_r;
   logic          e_toggle;

   assign e_toggle = (e_cnt_r == E_LAST);

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         e_cnt_r <= '0;
         e_clk_r <= 1'b0;
      end
      else
      begin
         e_cnt_r <= e_toggle ? '0 : e_cnt_r + EW'(1);
         if (e_toggle)
            e_clk_r <= ~e_clk_r; // R22
      end
   end

   assign e_clk     = e_clk_r;
   assign phase_two = e_clk_r;

   // Control and address buffering toward the system bus
   assign buffered_addr         = cpu_addr;
   assign buffered_rw           = cpu_rw;
   assign buffered_valid_access = valid_memory_access;
   assign dma_grant             = bus_available;

   // Address fields
   wire [2:0] top3      = cpu_addr[A_BIT15:A_BIT13];
   wire [1:0] top2      = cpu_addr[A_BIT15:A_BIT14];
   wire [1:0] rom_bank  = cpu_addr[A_BIT12:A_BIT11];
   wire       vec_hit   = (cpu_addr >= VECTOR_BASE);
   wire       timer_fld = (cpu_addr[A_BIT12:A_BIT12-3] == TIMER_FIELD);

   // I/O space, 8000-9FFF
   assign io_space_enable          = (top3 == IO_SPACE_TOP) & valid_memory_access; // R11
   assign buffered_io_space_enable = io_space_enable;                               // R11
   assign sel.timer_select         = buffered_io_space_enable & timer_fld;          // R03
   assign timer_reg_select         = cpu_addr[2:0];                                 // R04

   // ROM: A000-BFFF plus the FFF8-FFFF vector alias; C000-DFFF is never decoded here
   assign rom_enable_decode = (top3 == ROM_SPACE_TOP); // R16

   wire [3:0] rom_dec = rom_enable_decode ? (4'h1 << rom_bank) : 4'h0; // R17

   assign sel.rom_select_first  = ~cfg_4k_r & rom_dec[0];                   // R14
   assign sel.rom_select_second = ~cfg_4k_r & rom_dec[1];                   // R14
   assign sel.rom_select_third  = cfg_4k_r ? (rom_dec[0] | rom_dec[1])      // R15
                                           : rom_dec[2];                    // R14
   assign sel.rom_select_fourth = (cfg_4k_r ? (rom_dec[2] | rom_dec[3])     // R15
                                            : rom_dec[3])                   // R13
                                | vec_hit;                                  // R12

   // RAM: 0000-07FF, two banks of 1K
   assign ram_enable_decode = (top2 == RAM_SPACE_TOP) & phase_two; // R18

   wire ram_lo_win = ram_enable_decode & ~cpu_addr[A_BIT13] & ~cpu_addr[A_BIT11]; // R23

   assign sel.ram_lower_bank_select = ram_lo_win & ~cpu_addr[A_BIT10]; // R19
   assign sel.ram_upper_bank_select = ram_lo_win &  cpu_addr[A_BIT10]; // R19

   // Both nibble devices of a bank share its select
   assign ram_nibble_select_lo = {2{sel.ram_lower_bank_select}}; // R20
   assign ram_nibble_select_hi = {2{sel.ram_upper_bank_select}}; // R20

   assign ram_write_n = ~(~cpu_rw & valid_memory_access & phase_two); // R21

   // Data buffer direction, both tri-stated outside phase two
   assign buf_en.buffer_drive_enable   = ~cpu_rw & ~bus_available & phase_two;        // R08 R10
   assign buf_en.buffer_receive_enable = cpu_rw & cpu_addr[A_BIT15]                   // R09
                                       & ~cpu_addr[A_BIT13] & phase_two;              // R10

   // Timer outputs routed onward
   assign cpu_irq_n       = irq_s;       // R06
   assign tone_test_point = timer2_tone; // R07

endmodule
`default_nettype wire

// File: logic/cbad_pkg.sv
/*
 Shared constants and types of the processor board glue logic:
 address decode fields, timing figures and the select bundle.
 Assumes a 16-bit processor address bus and a single system clock.
*/
`default_nettype none
package cbad_pkg;
   // Timing
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned POR_MS        = 20;
   localparam int unsigned POR_CYCLES    = (CLK_HZ / 1000) * POR_MS;
   localparam int unsigned XTAL_HZ       = 4_000_000;
   localparam int unsigned XTAL_DIV      = 4;
   localparam int unsigned E_HZ          = XTAL_HZ / XTAL_DIV;
   localparam int unsigned E_HALF_CYCLES = CLK_HZ / E_HZ / 2;
   localparam int unsigned TEST_TONE_HZ  = 120;

   // Address bit positions
   localparam int unsigned A_BIT10 = 10;
   localparam int unsigned A_BIT11 = 11;
   localparam int unsigned A_BIT12 = 12;
   localparam int unsigned A_BIT13 = 13;
   localparam int unsigned A_BIT14 = 14;
   localparam int unsigned A_BIT15 = 15;

   // Top bits A15..A13 of each space, A15..A14 for RAM
   localparam logic [2:0] IO_SPACE_TOP  = 3'h4;   // 8000-9FFF
   localparam logic [2:0] ROM_SPACE_TOP = 3'h5;   // A000-BFFF
   localparam logic [1:0] RAM_SPACE_TOP = 2'h0;   // A15,A14 low
   // Timer: A12..A9 all high inside the I/O space, 9E00-9FFF
   localparam logic [3:0] TIMER_FIELD   = 4'hF;
   // Vector alias window FFF8-FFFF
   localparam logic [15:0] VECTOR_BASE  = 16'hFFF8;

   typedef struct packed {
      logic rom_select_first;
      logic rom_select_second;
      logic rom_select_third;
      logic rom_select_fourth;
      logic ram_lower_bank_select;
      logic ram_upper_bank_select;
      logic timer_select;
   } cbad_sel_t;

   typedef struct packed {
      logic buffer_drive_enable;
      logic buffer_receive_enable;
   } cbad_buf_t;
endpackage
`default_nettype wire
